// ==== rtl/misc_config_pkg.sv ====
/*
 Package for the miscellaneous configuration register bank: offsets, field positions, reset values.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package misc_config_pkg;

	// ****************************************
	// Register indices and address width
	// ****************************************
	localparam logic [7:0] IDX_DIMMING_LDO = 8'h56;
	localparam logic [7:0] IDX_PWM_FREQ_REFRATIO = 8'h57;
	localparam logic [7:0] IDX_TIMEOUT_SUPPLY = 8'h58;
	localparam logic [7:0] IDX_ONDEMAND_DIAG = 8'h59;
	localparam int ADDR_W = 12;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int POS_AUTO_SS = 7;
	localparam int POS_REG_VOLT = 6;
	localparam int POS_EXP_DIM = 4;
	localparam int POS_PWM_FREQ = 4;
	localparam int POS_REF_RATIO = 0;
	localparam int POS_LINK_TIMEOUT = 4;
	localparam int POS_LOW_SUPPLY = 0;
	localparam int POS_DIAG_CURRENT = 4;
	localparam int POS_DIAG_PULSE = 0;

	// ****************************************
	// Writable masks, fixed reset values and the own-current code
	// ****************************************
	localparam logic [7:0] MASK_DIMMING_LDO = 8'hDF;
	localparam logic [7:0] MASK_PWM_FREQ_REFRATIO = 8'hF3;
	localparam logic [7:0] MASK_TIMEOUT_SUPPLY = 8'h7F;
	localparam logic [7:0] MASK_ONDEMAND_DIAG = 8'hFF;
	localparam logic [0:0] RST_AUTO_SS = 1'h0;
	localparam logic [3:0] RST_SPARE = 4'h0;
	localparam logic [7:0] RST_ZERO8 = 8'h00;
	localparam logic [7:0] DIAG_CURRENT_OWN = 8'h0F;

endpackage

// ==== rtl/misc_config_regs.sv ====
/*
 Miscellaneous configuration register bank of a multi-channel LED driver, as an APB slave.
 Assumes the nonvolatile shadow inputs are stable on pclk around reset release.
*/
`timescale 1ns/10ps
`default_nettype none

module misc_config_regs
	import misc_config_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nv_regulator_voltage_shadow,
	input wire logic nv_exponential_dimming_shadow,
	input wire logic [3:0] nv_pwm_frequency_shadow,
	input wire logic [1:0] nv_reference_ratio_shadow,
	input wire logic [2:0] nv_link_timeout_shadow,
	input wire logic [3:0] nv_low_supply_threshold_shadow,
	input wire logic [3:0] nv_ondemand_diag_current_shadow,
	input wire logic [3:0] nv_ondemand_diag_pulse_width_shadow,
	output logic auto_single_short_en,
	output logic regulator_voltage_sel,
	output logic exponential_dimming_en,
	output logic [3:0] pwm_frequency_sel,
	output logic [1:0] reference_ratio_sel,
	output logic [2:0] link_timeout_sel,
	output logic [3:0] low_supply_threshold_sel,
	output logic [3:0] ondemand_diag_current,
	output logic ondemand_diag_use_channel_current,
	output logic [3:0] ondemand_diag_pulse_width
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic loaded;
		logic [7:0] misc0;
		logic [7:0] misc1;
		logic [7:0] misc2;
		logic [7:0] misc3;
		logic own_current;
		logic [31:0] rdata;
	} state_t;

	state_t cur;
	state_t next_cur;

	// Decodes a byte address to a register slot; 4 means unmapped
	function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
		logic [2:0] slot;
		slot = 3'h4;
		if (a[1:0] == 2'h0) begin
			if (a[ADDR_W-1:2] == {2'h0, IDX_DIMMING_LDO})
				slot = 3'h0;
			else if (a[ADDR_W-1:2] == {2'h0, IDX_PWM_FREQ_REFRATIO})
				slot = 3'h1;
			else if (a[ADDR_W-1:2] == {2'h0, IDX_TIMEOUT_SUPPLY})
				slot = 3'h2;
			else if (a[ADDR_W-1:2] == {2'h0, IDX_ONDEMAND_DIAG})
				slot = 3'h3;
		end
		return slot;
	endfunction

	// Masked byte write: only writable bits change when lane 0 is strobed
	function automatic logic [7:0] wr(input logic [7:0] old, input logic [7:0] mask);
		logic [7:0] v;
		v = old;
		if (pstrb[0])
			v = (old & ~mask) | (pwdata[7:0] & mask);
		return v;
	endfunction

	logic [2:0] slot;
	logic access;

	assign slot = decode(paddr);
	assign access = psel && penable;

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_cur = cur;
		// Shadow load on the first edge after reset release; after that only APB writes change the registers
		if (!cur.loaded) begin
			next_cur.loaded = 1'b1;
			next_cur.misc0 = {RST_AUTO_SS, nv_regulator_voltage_shadow, 1'b0,
				nv_exponential_dimming_shadow, RST_SPARE};
			next_cur.misc1 = {nv_pwm_frequency_shadow, 2'h0, nv_reference_ratio_shadow};
			next_cur.misc2 = {1'b0, nv_link_timeout_shadow, nv_low_supply_threshold_shadow};
			next_cur.misc3 = {nv_ondemand_diag_current_shadow, nv_ondemand_diag_pulse_width_shadow};
		end else if (access && pwrite) begin
			unique case (slot)
				3'h0: begin
					next_cur.misc0 = wr(cur.misc0, MASK_DIMMING_LDO);
				end
				3'h1: begin
					next_cur.misc1 = wr(cur.misc1, MASK_PWM_FREQ_REFRATIO);
				end
				3'h2: begin
					next_cur.misc2 = wr(cur.misc2, MASK_TIMEOUT_SUPPLY);
				end
				3'h3: begin
					next_cur.misc3 = wr(cur.misc3, MASK_ONDEMAND_DIAG);
				end
				default: begin
				end
			endcase
		end
		// Decoded beside the code so the flag leaves a flip-flop, in step with the current field
		next_cur.own_current = (next_cur.misc3[POS_DIAG_CURRENT +: 4] == DIAG_CURRENT_OWN[3:0]);
		// Read data captured in the setup cycle so prdata comes from a flip-flop in the access phase
		if (psel && !penable && !pwrite) begin
			unique case (slot)
				3'h0: begin
					next_cur.rdata = {24'h000000, cur.misc0 & MASK_DIMMING_LDO};
				end
				3'h1: begin
					next_cur.rdata = {24'h000000, cur.misc1 & MASK_PWM_FREQ_REFRATIO};
				end
				3'h2: begin
					next_cur.rdata = {24'h000000, cur.misc2 & MASK_TIMEOUT_SUPPLY};
				end
				3'h3: begin
					next_cur.rdata = {24'h000000, cur.misc3};
				end
				default: begin
					next_cur.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// ****************************************
	// Bus answer and field outputs
	// ****************************************
	// Zero wait states; unmapped or misaligned addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && (slot == 3'h4);
	assign prdata = cur.rdata;

	assign auto_single_short_en = cur.misc0[POS_AUTO_SS];
	assign regulator_voltage_sel = cur.misc0[POS_REG_VOLT];
	assign exponential_dimming_en = cur.misc0[POS_EXP_DIM];
	assign pwm_frequency_sel = cur.misc1[POS_PWM_FREQ +: 4];
	assign reference_ratio_sel = cur.misc1[POS_REF_RATIO +: 2];
	assign link_timeout_sel = cur.misc2[POS_LINK_TIMEOUT +: 3];
	assign low_supply_threshold_sel = cur.misc2[POS_LOW_SUPPLY +: 4];
	assign ondemand_diag_current = cur.misc3[POS_DIAG_CURRENT +: 4];
	assign ondemand_diag_use_channel_current = cur.own_current;
	assign ondemand_diag_pulse_width = cur.misc3[POS_DIAG_PULSE +: 4];

endmodule

`default_nettype wire

// ==== testbench/misc_config_regs_assertions.sv ====
/*
 Checker on the register bank ports.
 Assumes zero-wait APB.
*/
`timescale 1ns/10ps
`default_nettype none
module misc_config_regs_assertions
	import misc_config_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic [3:0] pwm_frequency_sel,
	input wire logic [3:0] ondemand_diag_current,
	input wire logic ondemand_diag_use_channel_current
);
	logic wr, rq, p1, p3;
	assign wr = psel & penable & pwrite & pstrb[0];
	assign rq = psel & penable & !pwrite;
	assign p1 = paddr == 12'h15C;
	assign p3 = paddr == 12'h164;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_pwm_wr: assert property (wr && p1 |=> pwm_frequency_sel == $past(pwdata[7:4])) else $error("pwm");
	chk_pwm_hold: assert property (wr && !p1 |=> $stable(pwm_frequency_sel)) else $error("pwm hold");
	chk_pwm_rd: assert property (rq && p1 |-> prdata[7:4] == pwm_frequency_sel) else $error("pwm read");
	chk_diag_wr: assert property (wr && p3 |=> ondemand_diag_current == $past(pwdata[7:4])) else $error("diag");
	chk_diag_hold: assert property (wr && !p3 |=> $stable(ondemand_diag_current)) else $error("diag hold");
	chk_own_cur: assert property (ondemand_diag_use_channel_current == (ondemand_diag_current == 4'hF)) else $error("own");
	chk_diag_rd: assert property (rq && p3 |-> prdata[31:4] == {24'h0, ondemand_diag_current}) else $error("diag read");
	chk_rsv_zero: assert property (rq && p1 |-> (prdata & 32'hFFFFFF0C) == 32'h0) else $error("reserved");
	cover property (wr && p3);
	cover property (rq && p1);
	cover property (ondemand_diag_use_channel_current);
endmodule
bind misc_config_regs misc_config_regs_assertions chk (.*);
`default_nettype wire

// ==== testbench/misc_config_regs_tb_top.sv ====
/*
 Bench for the register bank: rows, code sweep, unmapped read, second reset.
 Assumes zero-wait APB at 200 MHz.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s %h %h", n, e, g); end end
module misc_config_regs_tb_top;
	import misc_config_pkg::*;
	typedef struct packed {logic w; logic [11:0] a; logic [7:0] d, e;} row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [3:0] pstrb = '0, pwm_frequency_sel, low_supply_threshold_sel, ondemand_diag_current, ondemand_diag_pulse_width;
	logic [1:0] reference_ratio_sel;
	logic [2:0] link_timeout_sel;
	logic auto_single_short_en, regulator_voltage_sel, exponential_dimming_en, ondemand_diag_use_channel_current;
	logic [19:0] fld;
	logic [22:0] nv = '0;
	int fail_count = 0, samples_checked = 0;
	row_t rows [7] = '{'{1, 12'h158, 8'hFF, 8'hDF}, '{1, 12'h15C, 8'hAF, 8'hA3}, '{1, 12'h160, 8'hFF, 8'h7F},
		'{0, 12'h158, 0, 8'h40}, '{0, 12'h15C, 0, 8'h91}, '{0, 12'h160, 0, 8'h53}, '{0, 12'h164, 0, 8'hC7}};
	assign fld = {pwm_frequency_sel, link_timeout_sel, low_supply_threshold_sel, ondemand_diag_current,
		ondemand_diag_use_channel_current, ondemand_diag_pulse_width};
	misc_config_regs dut (.*, .nv_regulator_voltage_shadow(nv[22]), .nv_exponential_dimming_shadow(nv[21]),
		.nv_pwm_frequency_shadow(nv[20:17]), .nv_reference_ratio_shadow(nv[16:15]), .nv_link_timeout_shadow(nv[14:12]),
		.nv_low_supply_threshold_shadow(nv[11:8]), .nv_ondemand_diag_current_shadow(nv[7:4]),
		.nv_ondemand_diag_pulse_width_shadow(nv[3:0]));
	initial forever #2.5 pclk = ~pclk;
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= {3'h0, w};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic run_row(input int i);
		if (rows[i].w) xfer(1, rows[i].a, rows[i].d);
		xfer(0, rows[i].a, 8'h00);
		`CHK("readback", {24'h0, rows[i].e}, rd)
	endtask
	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		for (int i = 0; i < 3; i++) run_row(i);
		`CHK("direct", 5'h1F, {auto_single_short_en, regulator_voltage_sel, exponential_dimming_en, reference_ratio_sel})
		for (int i = 0; i < 16; i++) begin
			xfer(1, 12'h15C, {i[3:0], 4'h3});
			xfer(1, 12'h160, {1'h0, i[2:0], i[3:0]});
			xfer(1, 12'h164, {i[3:0], i[3:0]});
			#1;
			`CHK("fields", {i[3:0], i[2:0], i[3:0], i[3:0], i == 15, i[3:0]}, fld)
		end
		xfer(0, 12'h168, 8'h00);
		`CHK("unmapped", {1'h1, 32'h0}, {err, rd})
		@(posedge pclk);
		nv <= 23'h52D3C7;
		presetn <= 0;
		repeat (3) @(posedge pclk);
		`CHK("in reset", 25'h0, {fld, auto_single_short_en, regulator_voltage_sel, exponential_dimming_en, reference_ratio_sel})
		presetn <= 1;
		repeat (2) @(posedge pclk);
		`CHK("shadow", 6'h13, {auto_single_short_en, regulator_voltage_sel, exponential_dimming_en, reference_ratio_sel, pready})
		for (int i = 3; i < 7; i++) run_row(i);
		final_report();
	end
endmodule
`default_nettype wire
